//--- shared/acr_pkg.sv
// Constants for the converter control and result/compare register block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one word per register.
package acr_pkg;
    // ========================================================================
    // Register byte offsets
    localparam logic [4:0] OFS_SC1 = 5'h00;
    localparam logic [4:0] OFS_SC2 = 5'h04;
    localparam logic [4:0] OFS_RH  = 5'h08;
    localparam logic [4:0] OFS_RL  = 5'h0C;
    localparam logic [4:0] OFS_CVH = 5'h10;
    localparam logic [4:0] OFS_CVL = 5'h14;
    localparam logic [4:0] OFS_CFG = 5'h18;

    // ========================================================================
    // Field positions
    localparam int SC1_CPLT  = 7;
    localparam int SC1_CONT  = 5;
    localparam int SC2_ACT   = 7;
    localparam int SC2_TRIG  = 6;
    localparam int SC2_CMPEN = 5;
    localparam int SC2_CMPGT = 4;
    localparam int CFG_LP    = 7;
    localparam int CFG_DIV   = 5;
    localparam int CFG_LSMP  = 4;
    localparam int CFG_MODE  = 2;
    localparam int CFG_ICLK  = 0;

    // ========================================================================
    // Reset values and codes
    localparam logic [4:0] CHAN_OFF = 5'h1F;
    localparam logic [7:0] CFG_RST  = 8'h00;
    localparam logic [1:0] MODE_8   = 2'h0;
    localparam logic [1:0] MODE_10  = 2'h2;
    localparam logic [1:0] ICLK_BUS = 2'h0;
    localparam logic [1:0] ICLK_HALF = 2'h1;
    localparam logic [1:0] ICLK_ALT = 2'h2;
    localparam logic [1:0] ICLK_ASYNC = 2'h3;

    // ========================================================================
    // Conversion timing, in conversion clock ticks
    localparam logic [4:0] SAMPLE_SHORT = 5'h04;
    localparam logic [4:0] SAMPLE_LONG  = 5'h14;
    localparam logic [4:0] BITS_8       = 5'h08;
    localparam logic [4:0] BITS_10      = 5'h0A;
    // Bus cycles per tick of the stand-in internal asynchronous clock
    localparam logic [3:0] ASYNC_DIV    = 4'hA;

    // Conversion sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONV   = 3'b100
    } acr_state_t;
endpackage : acr_pkg

//--- hdl/acr_tick_gen.sv
// Conversion clock tick generator: source select and power-of-two divide.
// Assumes the alternate clock is slow and synchronous to the bus clock.
`timescale 1ns/10ps
module acr_tick_gen (
    input  wire logic       i_clk,        // Bus clock
    input  wire logic       i_rst,        // Sync reset, high
    input  wire logic [1:0] i_clk_select, // Input clock source
    input  wire logic [1:0] i_div_select, // Divide 1/2/4/8
    input  wire logic       i_alt_clk,    // Alternate clock level
    input  wire logic       i_run,        // Conversion running
    output logic            o_tick        // One-cycle tick pulse
);
    typedef struct packed {
        logic       half;
        logic       alt_prev;
        logic [3:0] acnt;
        logic [2:0] dcnt;
        logic       tick;
    } acr_tick_t;

    acr_tick_t q;
    acr_tick_t d;
    logic      src_en;

    // ========================================================================
    // Divider terminal count for a divide select
    function automatic logic [2:0] div_limit(input logic [1:0] sel);
        div_limit = 3'((4'h1 << sel) - 4'h1);
    endfunction : div_limit

    // ========================================================================
    // Source enable, then divide; the divider restarts while idle
    always_comb begin
        d          = q;
        d.half     = ~q.half;
        d.alt_prev = i_alt_clk;
        d.acnt     = (q.acnt == acr_pkg::ASYNC_DIV - 4'h1) ? 4'h0 : q.acnt + 4'h1;
        unique case (i_clk_select)
            acr_pkg::ICLK_BUS:  src_en = 1'b1;
            acr_pkg::ICLK_HALF: src_en = q.half;
            acr_pkg::ICLK_ALT:  src_en = i_alt_clk & ~q.alt_prev;
            acr_pkg::ICLK_ASYNC: src_en = (q.acnt == 4'h0);
        endcase
        d.tick = 1'b0;
        if (!i_run) begin
            d.dcnt = 3'h0;
        end else if (src_en) begin
            if (q.dcnt == div_limit(i_div_select)) begin
                d.dcnt = 3'h0;
                d.tick = 1'b1;
            end else begin
                d.dcnt = q.dcnt + 3'h1;
            end
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_tick = q.tick;
endmodule : acr_tick_gen

//--- hdl/acr_top.sv
// Converter control, result and compare registers behind an Avalon-MM slave.
// Assumes the analog core presents a settled 10-bit code on I_CONV_DATA
// by the last conversion tick; the core itself is outside this block.
//
// Functional notes
// - Active status sets when a conversion starts, clears on completion or abort.
// - Trigger select picks software write start or hardware trigger start.
// - Compare enable turns the automatic compare function on or off.
// - Sense 0 matches result below compare value; 1 matches at or above.
// - Result high holds upper two bits; zero in 8-bit mode.
// - Result low holds lower eight bits, or whole 8-bit result.
// - Results load every conversion unless compare enabled and condition false.
// - 10-bit mode: reading result high blocks result updates until low read.
// - Results completing while blocked are discarded, never stored.
// - 8-bit mode: no interlock between result high and result low.
// - After a mode change result contents are undefined until next store.
// - Compare high bits used only in 10-bit mode, ignored in 8-bit.
// - Compare low byte is compared with lower result byte in both modes.
// - Config bit 7 selects high speed or low power.
// - Config bits 6:5 divide the input clock by 1, 2, 4 or 8.
// - Config bit 4 selects short or long sample time.
// - Mode field: 00 is 8-bit, 10 is 10-bit, others reserved.
// - Input clock: bus, bus/2, alternate or internal asynchronous clock.
// - Complete flag sets only on true compare when compare is enabled.
// - Writing status/control one aborts; starts new in software trigger mode unless channel all ones.
// - Complete flag clears on status/control one write or result low read.
`timescale 1ns/10ps
module acr_top (
    input  wire logic        I_CLK,        // Bus clock, 40 MHz
    input  wire logic        I_RST,        // Sync reset, high
    input  wire logic [4:0]  I_ADDRESS,    // Byte address
    input  wire logic        I_READ,       // Avalon read
    input  wire logic        I_WRITE,      // Avalon write
    input  wire logic [3:0]  I_BYTEENABLE, // Byte lanes
    input  wire logic [31:0] I_WRITEDATA,  // Write data
    output logic      [31:0] O_READDATA,   // Read data
    output logic             O_WAITREQUEST, // Wait, high
    input  wire logic        I_HW_TRIG,    // Hardware trigger in
    input  wire logic        I_ALT_CLK,    // Alternate clock level
    input  wire logic [9:0]  I_CONV_DATA,  // Code from analog core
    output logic      [4:0]  O_CHANNEL,    // Channel to core
    output logic             O_START,      // Start pulse to core
    output logic             O_SAMPLE,     // Sampling phase
    output logic             O_ACTIVE,     // Conversion active
    output logic             O_COMPLETE,   // Complete flag
    output logic             O_LOW_POWER,  // Low power setting
    output logic             O_LONG_SAMPLE, // Long sample setting
    output logic      [1:0]  O_MODE,       // Conversion mode field
    output logic             O_CONV_TICK   // Conversion clock tick
);
    // ========================================================================
    // State
    typedef struct packed {
        acr_pkg::acr_state_t st;
        logic [4:0]  cnt;
        logic [4:0]  chan;
        logic        cont;
        logic        cplt;
        logic        active;
        logic        sampling;
        logic        start;
        logic        trig_sel;
        logic        cmp_en;
        logic        cmp_gt;
        logic [1:0]  cvh;
        logic [7:0]  cvl;
        logic [7:0]  cfg;
        logic [9:0]  res;
        logic        lock;
        logic        trig_prev;
        logic        waitreq;
        logic [31:0] rdata;
    } acr_regs_t;

    localparam acr_regs_t REGS_RST = '{
        st:       acr_pkg::ST_IDLE,
        cnt:      5'h00,
        chan:     acr_pkg::CHAN_OFF,
        cont:     1'b0,
        cplt:     1'b0,
        active:   1'b0,
        sampling: 1'b0,
        start:    1'b0,
        trig_sel: 1'b0,
        cmp_en:   1'b0,
        cmp_gt:   1'b0,
        cvh:      2'h0,
        cvl:      8'h00,
        cfg:      acr_pkg::CFG_RST,
        res:      10'h000,
        lock:     1'b0,
        trig_prev: 1'b0,
        waitreq:  1'b1,
        rdata:    32'h0000_0000
    };

    acr_regs_t q;
    acr_regs_t d;

    logic        tick;
    logic        ten_bit;
    logic        acc;
    logic        wr;
    logic        rd;
    logic        wr_sc1;
    logic [4:0]  new_chan;
    logic        sw_start;
    logic        hw_start;
    logic        done;
    logic [9:0]  value;
    logic [9:0]  cmp_val;
    logic        store;
    logic        cplt_set;
    logic        cplt_clr;

    // ========================================================================
    // Helpers
    // Compare condition for either sense
    function automatic logic cmp_true(input logic [9:0] r,
                                      input logic [9:0] cv,
                                      input logic       gt);
        cmp_true = gt ? (r >= cv) : (r < cv);
    endfunction : cmp_true

    // Sample length in ticks
    function automatic logic [4:0] sample_len(input logic lsmp);
        sample_len = lsmp ? acr_pkg::SAMPLE_LONG : acr_pkg::SAMPLE_SHORT;
    endfunction : sample_len

    // Register read multiplexer; unmapped addresses read zero
    function automatic logic [7:0] read_mux(input acr_regs_t s,
                                            input logic [4:0] a,
                                            input logic       ten);
        unique case (a)
            acr_pkg::OFS_SC1: read_mux = {s.cplt, 1'b0, s.cont, s.chan};
            acr_pkg::OFS_SC2: read_mux = {s.active, s.trig_sel, s.cmp_en,
                                          s.cmp_gt, 4'h0};
            acr_pkg::OFS_RH:  read_mux = {6'h00, ten ? s.res[9:8] : 2'h0};
            acr_pkg::OFS_RL:  read_mux = s.res[7:0];
            acr_pkg::OFS_CVH: read_mux = {6'h00, s.cvh};
            acr_pkg::OFS_CVL: read_mux = s.cvl;
            acr_pkg::OFS_CFG: read_mux = s.cfg;
            default:          read_mux = 8'h00;
        endcase
    endfunction : read_mux

    // ========================================================================
    // Conversion clock ticks
    acr_tick_gen u_tick (
        .i_clk        (I_CLK),
        .i_rst        (I_RST),
        .i_clk_select (q.cfg[acr_pkg::CFG_ICLK +: 2]),
        .i_div_select (q.cfg[acr_pkg::CFG_DIV +: 2]),
        .i_alt_clk    (I_ALT_CLK),
        .i_run        (d.active),
        .o_tick       (tick)
    );

    // ========================================================================
    // Bus decode: every access waits one cycle, then completes
    // Reserved mode codes behave as 8-bit so the width is never ambiguous
    assign ten_bit  = (q.cfg[acr_pkg::CFG_MODE +: 2] == acr_pkg::MODE_10);
    assign acc      = (I_READ | I_WRITE) & ~q.waitreq;
    assign wr       = acc & I_WRITE & I_BYTEENABLE[0];
    assign rd       = acc & I_READ;
    assign wr_sc1   = wr & (I_ADDRESS == acr_pkg::OFS_SC1);
    assign new_chan = I_WRITEDATA[4:0];

    // Start sources
    assign sw_start = wr_sc1 & ~q.trig_sel & (new_chan != acr_pkg::CHAN_OFF);
    assign hw_start = q.trig_sel & I_HW_TRIG & ~q.trig_prev
                    & (q.chan != acr_pkg::CHAN_OFF) & (q.st == acr_pkg::ST_IDLE);

    // Completion and compare
    assign done    = (q.st == acr_pkg::ST_CONV) & tick
                   & (q.cnt == (ten_bit ? acr_pkg::BITS_10 : acr_pkg::BITS_8) - 5'h01);
    assign value   = ten_bit ? I_CONV_DATA : {2'h0, I_CONV_DATA[7:0]};
    assign cmp_val = ten_bit ? {q.cvh, q.cvl} : {2'h0, q.cvl};
    assign store   = done & (~q.cmp_en | cmp_true(value, cmp_val, q.cmp_gt));
    assign cplt_set = store;
    assign cplt_clr = wr_sc1 | (rd & (I_ADDRESS == acr_pkg::OFS_RL));

    // ========================================================================
    // Next-state logic
    always_comb begin
        d           = q;
        d.start     = 1'b0;
        d.trig_prev = I_HW_TRIG;

        // One wait cycle per access; read data snapshot taken with it
        d.waitreq = ~((I_READ | I_WRITE) & q.waitreq);
        if ((I_READ | I_WRITE) & q.waitreq) begin
            d.rdata = {24'h000000, read_mux(q, I_ADDRESS, ten_bit)};
        end

        // Sequencer
        unique case (q.st)
            acr_pkg::ST_IDLE: begin
                if (hw_start) begin
                    d.st       = acr_pkg::ST_SAMPLE;
                    d.cnt      = 5'h00;
                    d.active   = 1'b1;
                    d.sampling = 1'b1;
                    d.start    = 1'b1;
                end
            end
            acr_pkg::ST_SAMPLE: begin
                if (tick) begin
                    if (q.cnt == sample_len(q.cfg[acr_pkg::CFG_LSMP]) - 5'h01) begin
                        d.st       = acr_pkg::ST_CONV;
                        d.cnt      = 5'h00;
                        d.sampling = 1'b0;
                    end else begin
                        d.cnt = q.cnt + 5'h01;
                    end
                end
            end
            acr_pkg::ST_CONV: begin
                if (done) begin
                    // Continuous mode re-arms at once
                    if (q.cont & (q.chan != acr_pkg::CHAN_OFF)) begin
                        d.st       = acr_pkg::ST_SAMPLE;
                        d.sampling = 1'b1;
                        d.start    = 1'b1;
                    end else begin
                        d.st     = acr_pkg::ST_IDLE;
                        d.active = 1'b0;
                    end
                    d.cnt = 5'h00;
                end else if (tick) begin
                    d.cnt = q.cnt + 5'h01;
                end
            end
            default: begin
                d.st     = acr_pkg::ST_IDLE;
                d.active = 1'b0;
            end
        endcase

        // Result store; a held interlock drops the new code
        if (store & ~q.lock) begin
            d.res = value;
        end

        // Writing control one aborts, then restarts by software trigger
        if (wr_sc1) begin
            d.chan     = new_chan;
            d.cont     = I_WRITEDATA[acr_pkg::SC1_CONT];
            d.st       = acr_pkg::ST_IDLE;
            d.active   = 1'b0;
            d.sampling = 1'b0;
            d.start    = 1'b0;
            d.cnt      = 5'h00;
            if (sw_start) begin
                d.st       = acr_pkg::ST_SAMPLE;
                d.active   = 1'b1;
                d.sampling = 1'b1;
                d.start    = 1'b1;
            end
        end

        // Other writable registers; active bit is never written
        if (wr) begin
            unique case (I_ADDRESS)
                acr_pkg::OFS_SC2: begin
                    d.trig_sel = I_WRITEDATA[acr_pkg::SC2_TRIG];
                    d.cmp_en   = I_WRITEDATA[acr_pkg::SC2_CMPEN];
                    d.cmp_gt   = I_WRITEDATA[acr_pkg::SC2_CMPGT];
                end
                acr_pkg::OFS_CVH: d.cvh = I_WRITEDATA[1:0];
                acr_pkg::OFS_CVL: d.cvl = I_WRITEDATA[7:0];
                acr_pkg::OFS_CFG: d.cfg = I_WRITEDATA[7:0];
                default: ;
            endcase
        end

        // Interlock: result high read locks, result low read frees
        if (rd & (I_ADDRESS == acr_pkg::OFS_RH) & ten_bit) begin
            d.lock = 1'b1;
        end
        if (rd & (I_ADDRESS == acr_pkg::OFS_RL)) begin
            d.lock = 1'b0;
        end
        if (!ten_bit) begin
            d.lock = 1'b0;
        end

        // Complete flag: a set in the clearing cycle wins
        d.cplt = cplt_set | (q.cplt & ~cplt_clr);
    end

    // ========================================================================
    // State register
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            q <= REGS_RST;
        end else begin
            q <= d;
        end
    end

    // ========================================================================
    // Outputs, all straight from flops
    assign O_READDATA    = q.rdata;
    assign O_WAITREQUEST = q.waitreq;
    assign O_CHANNEL     = q.chan;
    assign O_START       = q.start;
    assign O_SAMPLE      = q.sampling;
    assign O_ACTIVE      = q.active;
    assign O_COMPLETE    = q.cplt;
    assign O_LOW_POWER   = q.cfg[acr_pkg::CFG_LP];
    assign O_LONG_SAMPLE = q.cfg[acr_pkg::CFG_LSMP];
    assign O_MODE        = q.cfg[acr_pkg::CFG_MODE +: 2];
    assign O_CONV_TICK   = tick;
endmodule : acr_top

//--- testbench/acr_top_asserts.sv
// Checker for acr_top: bus handshake, conversion start, trigger and abort.
// Bound to acr_top; sees only its ports, tracks trigger select itself.
`timescale 1ns/10ps
module acr_top_asserts (
    input wire logic        I_CLK,         // Bus clock
    input wire logic        I_RST,         // Sync reset, high
    input wire logic [4:0]  I_ADDRESS,     // Byte address
    input wire logic        I_READ,        // Read request
    input wire logic        I_WRITE,       // Write request
    input wire logic [3:0]  I_BYTEENABLE,  // Byte lanes
    input wire logic [31:0] I_WRITEDATA,   // Write data
    input wire logic        O_WAITREQUEST, // Wait, high
    input wire logic        I_HW_TRIG,     // Hardware trigger
    input wire logic        O_START,       // Start pulse
    input wire logic        O_SAMPLE,      // Sample phase
    input wire logic        O_ACTIVE,      // Conversion active
    input wire logic [4:0]  O_CHANNEL,     // Channel select
    input wire logic        O_CONV_TICK    // Conversion tick
);
    // ======================================
    // Helper state
    logic wr_ok;
    logic wr_sc1;
    logic wr_sc2;
    logic trig_q;
    // A write lands only at the edge where waitrequest is low
    assign wr_ok  = I_WRITE && !O_WAITREQUEST && I_BYTEENABLE[0];
    assign wr_sc1 = wr_ok && (I_ADDRESS == acr_pkg::OFS_SC1);
    assign wr_sc2 = wr_ok && (I_ADDRESS == acr_pkg::OFS_SC2);
    // Shadow of trigger select
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            trig_q <= 1'b0;
        end else if (wr_sc2) begin
            trig_q <= I_WRITEDATA[acr_pkg::SC2_TRIG];
        end
    end
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    // ======================================
    // Sequences
    sequence s_req;
        (I_READ || I_WRITE) && O_WAITREQUEST;
    endsequence
    sequence s_sw_go;
        wr_sc1 && !trig_q && (I_WRITEDATA[4:0] != acr_pkg::CHAN_OFF);
    endsequence
    sequence s_run;
        O_START && O_ACTIVE && O_SAMPLE ##1 O_ACTIVE && !O_START;
    endsequence
    // ======================================
    // Assertions
    bus_answer_a: assert property (s_req |=> !O_WAITREQUEST)
        else $error("request not answered in one cycle");
    answer_pulse_a: assert property (!O_WAITREQUEST |=> O_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    sw_start_a: assert property (s_sw_go |=> s_run)
        else $error("software start missing or malformed");
    hw_start_a: assert property (trig_q && $rose(I_HW_TRIG) && !O_ACTIVE
        && !wr_sc1 && !(&O_CHANNEL) |=> s_run)
        else $error("hardware edge did not start");
    hw_write_a: assert property (wr_sc1 && trig_q |=> !O_START)
        else $error("write started a conversion in hardware mode");
    abort_idle_a: assert property (wr_sc1 && I_WRITEDATA[4:0] == acr_pkg::CHAN_OFF |=> !O_ACTIVE [*2])
        else $error("abort left conversion active");
    tick_active_a: assert property (O_CONV_TICK |-> O_ACTIVE)
        else $error("tick outside a conversion");
    sample_start_a: assert property ($rose(O_SAMPLE) |-> O_START && O_ACTIVE)
        else $error("sample phase began without a start");
endmodule : acr_top_asserts

bind acr_top acr_top_asserts u_acr_top_asserts (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_ADDRESS(I_ADDRESS), .I_READ(I_READ),
    .I_WRITE(I_WRITE), .I_BYTEENABLE(I_BYTEENABLE), .I_WRITEDATA(I_WRITEDATA),
    .O_WAITREQUEST(O_WAITREQUEST), .I_HW_TRIG(I_HW_TRIG), .O_START(O_START),
    .O_SAMPLE(O_SAMPLE), .O_ACTIVE(O_ACTIVE), .O_CONV_TICK(O_CONV_TICK), .O_CHANNEL(O_CHANNEL)
);

//--- testbench/acr_top_bench.sv
// Self-checking bench for acr_top with an integer reference model.
// Random codes on I_CONV_DATA stand in for the analog core.
`timescale 1ns/10ps
module acr_top_bench;
    // ======================================
    // Ports and model state
    logic        I_CLK = 1'b0;
    logic        I_RST = 1'b1;
    logic [4:0]  I_ADDRESS = 5'h00;
    logic        I_READ = 1'b0;
    logic        I_WRITE = 1'b0;
    logic [3:0]  I_BYTEENABLE = 4'h0;
    logic [31:0] I_WRITEDATA = 32'h0;
    logic        I_HW_TRIG = 1'b0;
    logic        I_ALT_CLK = 1'b0;
    logic [9:0]  I_CONV_DATA = 10'h000;
    logic [31:0] O_READDATA;
    logic [4:0]  O_CHANNEL;
    logic [1:0]  O_MODE;
    logic        O_WAITREQUEST, O_START, O_SAMPLE, O_ACTIVE, O_COMPLETE;
    logic        O_LOW_POWER, O_LONG_SAMPLE, O_CONV_TICK;
    logic [7:0]  rdata, v;
    logic [9:0]  d;
    int n_errors, cmp_count, seed, cyc, ntk, t1, t2;
    int cplt, lockd, undef = 1, m10, cen, gt, cv;
    int rh, rl, chan = 31, dv, src, ls;

    acr_top u_acr_top (
        .I_CLK(I_CLK), .I_RST(I_RST), .I_ADDRESS(I_ADDRESS), .I_READ(I_READ),
        .I_WRITE(I_WRITE), .I_BYTEENABLE(I_BYTEENABLE), .I_WRITEDATA(I_WRITEDATA),
        .O_READDATA(O_READDATA), .O_WAITREQUEST(O_WAITREQUEST), .I_HW_TRIG(I_HW_TRIG),
        .I_ALT_CLK(I_ALT_CLK), .I_CONV_DATA(I_CONV_DATA), .O_CHANNEL(O_CHANNEL),
        .O_START(O_START), .O_SAMPLE(O_SAMPLE), .O_ACTIVE(O_ACTIVE),
        .O_COMPLETE(O_COMPLETE), .O_LOW_POWER(O_LOW_POWER),
        .O_LONG_SAMPLE(O_LONG_SAMPLE), .O_MODE(O_MODE), .O_CONV_TICK(O_CONV_TICK)
    );

    // Clock; alternate clock rises every second bus cycle
    always #12.5 I_CLK = ~I_CLK;
    always @(posedge I_CLK) I_ALT_CLK <= ~I_ALT_CLK;
    // Tick monitor at the falling edge, where outputs are settled
    always @(negedge I_CLK) begin
        cyc++;
        if (O_CONV_TICK === 1'b1) begin
            ntk++;
            if (ntk == 1) t1 = cyc;
            if (ntk == 2) t2 = cyc;
        end
    end
    // ======================================
    // Tasks
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Held until waitrequest is seen low at a rising edge
    task bus(input bit wr, input logic [4:0] a, input logic [7:0] dat);
        int n;
        n = 0;
        @(posedge I_CLK);
        {I_ADDRESS, I_WRITE, I_READ, I_BYTEENABLE, I_WRITEDATA} <= {a, wr, !wr, 4'hF, 24'h0, dat};
        do begin
            @(posedge I_CLK);
            n++;
        end while (O_WAITREQUEST !== 1'b0 && n < 50);
        rdata = O_READDATA[7:0];
        {I_READ, I_WRITE} <= 2'b00;
        if (n >= 50) n_errors++;
    endtask : bus
    task rd(input logic [4:0] a, input logic [7:0] e, input bit care = 1);
        bus(0, a, 8'h00);
        if (care) chk(rdata, e);
        if (a == acr_pkg::OFS_RH && m10) lockd = 1;
        if (a == acr_pkg::OFS_RL) {lockd, cplt} = 0;
    endtask : rd
    task cfg(input logic [7:0] c);
        bus(1, acr_pkg::OFS_CFG, c);
        if ((c[3:2] == acr_pkg::MODE_10) != m10) undef = 1;
        m10 = (c[3:2] == acr_pkg::MODE_10);
        if (!m10) lockd = 0;
        dv = c[6:5];
        ls = c[4];
        src = c[1:0];
    endtask : cfg
    task sc2(input logic [7:0] c);
        bus(1, acr_pkg::OFS_SC2, c);
        cen = c[5];
        gt = c[4];
    endtask : sc2
    task wcv(input logic [9:0] c);
        bus(1, acr_pkg::OFS_CVH, {6'h00, c[9:8]});
        bus(1, acr_pkg::OFS_CVL, c[7:0]);
        cv = c;
    endtask : wcv
    task res;
        rd(acr_pkg::OFS_SC1, {cplt[0], 2'b00, chan[4:0]});
        rd(acr_pkg::OFS_RH, rh[7:0], !undef);
        rd(acr_pkg::OFS_RL, rl[7:0], !undef);
    endtask : res
    // One conversion, then the model decides store and flag
    task conv(input bit hw, input logic [9:0] dat);
        int n, val, cvv, pass, per;
        n = 0;
        ntk = 0;
        if (hw) begin
            @(posedge I_CLK);
            I_HW_TRIG <= 1'b1;
            @(posedge I_CLK);
            I_HW_TRIG <= 1'b0;
        end else begin
            bus(1, acr_pkg::OFS_SC1, 8'h03);
            {cplt, chan} = {32'd0, 32'd3};
        end
        I_CONV_DATA <= dat;
        @(negedge I_CLK);
        chk({7'h0, O_ACTIVE}, 8'h01);
        while (O_ACTIVE === 1'b1 && n < 5000) begin
            @(negedge I_CLK);
            n++;
        end
        chk(8'(ntk), 8'(ls ? acr_pkg::SAMPLE_LONG : acr_pkg::SAMPLE_SHORT) + (m10 ? 8'h0A : 8'h08));
        per = ((src == 0) ? 1 : (src == 3) ? int'(acr_pkg::ASYNC_DIV) : 2) << dv;
        chk(8'(t2 - t1), 8'(per));
        val = m10 ? int'(dat) : int'(dat[7:0]);
        cvv = m10 ? cv : cv % 256;
        pass = !cen || (gt ? val >= cvv : val < cvv);
        if (pass) cplt = 1;
        chk({O_COMPLETE, 6'h0, O_ACTIVE}, {cplt[0], 7'h00});
        if (pass && !lockd) {rh, rl, undef} = {val / 256, val % 256, 32'd0};
    endtask : conv
    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    // ======================================
    // Watchdog: the whole run needs well under 20000 cycles
    initial begin
        repeat (60000) @(posedge I_CLK);
        n_errors++;
        print_verdict();
    end
    // Main sequence
    initial begin
        seed = $urandom(15);
        repeat (16) @(posedge I_CLK);
        I_RST <= 1'b0;
        rd(acr_pkg::OFS_CFG, 8'h00);
        rd(acr_pkg::OFS_SC2, 8'h00);
        rd(acr_pkg::OFS_SC1, 8'h1F);
        bus(1, 5'h1C, 8'hFF);
        rd(5'h1C, 8'h00);
        // Every clock source with every divide
        for (int i = 0; i < 16; i++) begin
            v = (8'($urandom) & 8'h98) | {1'b0, 2'(i), 3'h0, 2'(i >> 2)};
            cfg(v);
            rd(acr_pkg::OFS_CFG, v);
            chk({O_LOW_POWER, O_LONG_SAMPLE, O_MODE, 4'h0}, {v[7], v[4], v[3:2], 4'h0});
            conv(0, 10'($urandom));
            res();
        end
        // Compare in both senses, 10-bit then 8-bit, with equal values
        for (int i = 0; i < 16; i++) begin
            if (i % 8 == 0) begin
                cfg(i == 0 ? 8'h08 : 8'h00);
                sc2(8'h00);
                conv(0, 10'($urandom));
            end
            sc2({2'b00, 1'b1, i[0], 4'h0});
            wcv(10'($urandom));
            d = i[1] ? cv[9:0] : 10'($urandom);
            conv(0, d);
            res();
        end
        rd(acr_pkg::OFS_CVH, {6'h00, cv[9:8]});
        // Read interlock in 10-bit mode, none in 8-bit mode
        sc2(8'h00);
        cfg(8'h08);
        conv(0, 10'($urandom));
        rd(acr_pkg::OFS_RH, rh[7:0]);
        conv(0, 10'($urandom));
        res();
        conv(0, 10'($urandom));
        res();
        cfg(8'h00);
        conv(0, 10'($urandom));
        rd(acr_pkg::OFS_RH, 8'h00);
        conv(0, 10'($urandom));
        res();
        // Hardware trigger; active bit ignores writes
        sc2(8'hC0);
        rd(acr_pkg::OFS_SC2, 8'h40);
        bus(1, acr_pkg::OFS_SC1, 8'h03);
        {cplt, chan} = {32'd0, 32'd3};
        repeat (30) @(negedge I_CLK);
        chk({7'h0, O_ACTIVE}, 8'h00);
        conv(1, 10'($urandom));
        res();
        // Abort a slow conversion midway
        sc2(8'h00);
        cfg(8'h70);
        bus(1, acr_pkg::OFS_SC1, 8'h03);
        {cplt, chan} = {32'd0, 32'd3};
        repeat (20) @(negedge I_CLK);
        chk({7'h0, O_ACTIVE}, 8'h01);
        bus(1, acr_pkg::OFS_SC1, 8'h1F);
        chan = 31;
        @(negedge I_CLK);
        chk({O_ACTIVE, 2'b00, O_CHANNEL}, 8'h1F);
        res();
        print_verdict();
    end
endmodule : acr_top_bench
